// ===== design/pst_pkg.sv
// package: constants and types for the phase-selective trip logic
package pst_pkg;

    // ==================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned MS_MIN = 50;
    localparam int unsigned MS_MAX = 60000;
    localparam logic [15:0] MIN_PULSE_MS_RST = 16'h0096;
    localparam logic [15:0] EVOLVE_MS_RST = 16'h03e8;
    localparam logic [15:0] MS_MIN_16 = 16'h0032;
    localparam logic [15:0] MS_MAX_16 = 16'hea60;

    // ==================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MIN_PULSE = 8'h04;
    localparam logic [7:0] ADDR_EVOLVE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_EVENT = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;

    // ctrl fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned MODE_W = 2;

    // status fields: outputs live
    localparam int unsigned ST_PH1 = 0;
    localparam int unsigned ST_GEN = 3;
    localparam int unsigned ST_ALL = 4;
    localparam int unsigned ST_EVOLVE = 5;

    // event bits: [3:0]=on of ph1..3,gen, [7:4]=off of ph1..3,gen
    localparam int unsigned EV_W = 8;
    localparam logic [7:0] EV_RST = 8'h00;

    typedef enum logic [1:0] {
        PST_MODE_OFF = 2'h0,
        PST_MODE_3PH = 2'h1,
        PST_MODE_1PH3PH = 2'h2
    } pst_mode_t;

endpackage : pst_pkg

// ===== design/pst_trip_logic.sv
// phase-selective trip logic with wishbone register slave
// ==================================================
// How it works
// - mode register selects off, three-phase, or single/three-phase; off after reset
// - each trip output holds at least min pulse length, 50..60000 ms, default 150
// - evolving-fault wait settable 50..60000 ms, default 1000
// - new request after the general trip has dropped, while evolving wait runs, trips all three phases
// - two phase requests at once also trip the third phase
// - reclose needs met: three-phase request input gives a three-phase trip
// - force input widens single-phase requests to all three phases
// - block input holds every trip output low
// - one request input per phase identifies the faulted phase
// - one trip output per phase drives the first three trip contacts
// - general trip set whenever any trip is generated
// - dedicated three-phase output set whenever all three phases trip
// - on and off events recorded for phase and general trip outputs
// - disabled mode never asserts any trip output
module pst_trip_logic #(
    parameter int unsigned TICK_CYCLES = pst_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // request inputs from protection logic (same clock)
    input wire logic output_block_in_i,
    input wire logic single_phase_request_in_i,
    input wire logic three_phase_request_in_i,
    input wire logic phase1_request_in_i,
    input wire logic phase2_request_in_i,
    input wire logic phase3_request_in_i,
    input wire logic force_all_phases_in_i,
    // trip outputs
    output logic phase1_trip_out_o,
    output logic phase2_trip_out_o,
    output logic phase3_trip_out_o,
    output logic general_trip_out_o,
    output logic all_phase_trip_out_o,
    output logic irq_o
);

    // the prescaler counter is 16 bits wide, so larger tick dividers cannot be served
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // ==================================================
    // state
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
        logic [1:0] mode;
        logic [15:0] min_pulse;
        logic [15:0] evolve;
        logic [7:0] ev;
        logic [7:0] mask;
        logic [15:0] tick_cnt;
        logic [2:0] ph_trip;
        logic all_trip;
        logic gen_trip;
        logic [15:0] pulse_cnt;
        logic [15:0] evolve_cnt;
        logic evolve_run;
        logic irq;
    } pst_state_t;

    pst_state_t st_r;
    pst_state_t st_nxt;

    logic [2:0] ph_req;
    logic any_req;
    logic two_ph;
    logic widen;
    logic [2:0] want;
    logic tick;
    logic [7:0] ev_set;
    logic [7:0] ev_clr;
    logic wr;
    logic rd;
    logic [15:0] wval;

    always_comb begin
        st_nxt = st_r;
        ph_req = {phase3_request_in_i, phase2_request_in_i, phase1_request_in_i};
        // a bare single-phase request without phase info cannot pick a phase, so it is ignored
        any_req = (|ph_req) || three_phase_request_in_i;
        two_ph = (ph_req[0] & ph_req[1]) | (ph_req[1] & ph_req[2]) | (ph_req[0] & ph_req[2]);
        widen = three_phase_request_in_i
            || two_ph
            || force_all_phases_in_i
            || (st_r.evolve_run && !st_r.gen_trip)
            || (st_r.mode == pst_pkg::PST_MODE_3PH);
        want = widen ? 3'h7 : ph_req;
        tick = (st_r.tick_cnt == 16'(TICK_CYCLES - 1));
        wr = cyc_i && stb_i && we_i && !st_r.ack;
        rd = cyc_i && stb_i && !we_i && !st_r.ack;
        wval = dat_i[15:0];
        ev_clr = 8'h00;

        // ==================================================
        // tick prescaler
        st_nxt.tick_cnt = tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;

        // ==================================================
        // trip decision
        if (st_r.mode == pst_pkg::PST_MODE_OFF || output_block_in_i) begin
            st_nxt.ph_trip = 3'h0;
            st_nxt.all_trip = 1'b0;
            st_nxt.gen_trip = 1'b0;
            st_nxt.pulse_cnt = 16'h0000;
            st_nxt.evolve_run = 1'b0;
            st_nxt.evolve_cnt = 16'h0000;
        end else begin
            if (any_req) begin
                st_nxt.ph_trip = st_r.ph_trip | want;
                st_nxt.pulse_cnt = st_r.min_pulse;
                if (!st_r.gen_trip && !st_r.evolve_run) begin
                    st_nxt.evolve_run = 1'b1;
                    st_nxt.evolve_cnt = st_r.evolve;
                end
            end else if (st_r.gen_trip) begin
                if (st_r.pulse_cnt <= 16'h0001 && tick) begin
                    st_nxt.ph_trip = 3'h0;
                    st_nxt.pulse_cnt = 16'h0000;
                end else if (tick) begin
                    st_nxt.pulse_cnt = st_r.pulse_cnt - 16'h0001;
                end
            end
            if (st_r.evolve_run && tick && !any_req) begin
                if (st_r.evolve_cnt <= 16'h0001) begin
                    st_nxt.evolve_run = 1'b0;
                end else begin
                    st_nxt.evolve_cnt = st_r.evolve_cnt - 16'h0001;
                end
            end
            st_nxt.gen_trip = |st_nxt.ph_trip;
            st_nxt.all_trip = &st_nxt.ph_trip;
        end

        // ==================================================
        // events: on/off edges of phase and general outputs
        ev_set[3:0] = {st_nxt.gen_trip, st_nxt.ph_trip} & ~{st_r.gen_trip, st_r.ph_trip};
        ev_set[7:4] = ~{st_nxt.gen_trip, st_nxt.ph_trip} & {st_r.gen_trip, st_r.ph_trip};

        // ==================================================
        // wishbone slave, one wait state
        st_nxt.ack = cyc_i && stb_i && !st_r.ack;
        st_nxt.dat = 32'h0000_0000;
        if (wr && sel_i[0]) begin
            if (adr_i == pst_pkg::ADDR_CTRL) begin
                if (dat_i[1:0] != 2'h3) begin
                    st_nxt.mode = dat_i[pst_pkg::CTRL_MODE_LSB +: pst_pkg::MODE_W];
                end
            end else if (adr_i == pst_pkg::ADDR_EVENT) begin
                ev_clr = dat_i[7:0];
            end else if (adr_i == pst_pkg::ADDR_MASK) begin
                st_nxt.mask = dat_i[7:0];
            end
        end
        // range-checked timer settings; out-of-range writes are dropped
        if (wr && sel_i[1:0] == 2'h3 && wval >= pst_pkg::MS_MIN_16 && wval <= pst_pkg::MS_MAX_16) begin
            if (adr_i == pst_pkg::ADDR_MIN_PULSE) begin
                st_nxt.min_pulse = wval;
            end else if (adr_i == pst_pkg::ADDR_EVOLVE) begin
                st_nxt.evolve = wval;
            end
        end
        if (rd) begin
            if (adr_i == pst_pkg::ADDR_CTRL) begin
                st_nxt.dat = {30'h0, st_r.mode};
            end else if (adr_i == pst_pkg::ADDR_MIN_PULSE) begin
                st_nxt.dat = {16'h0, st_r.min_pulse};
            end else if (adr_i == pst_pkg::ADDR_EVOLVE) begin
                st_nxt.dat = {16'h0, st_r.evolve};
            end else if (adr_i == pst_pkg::ADDR_STATUS) begin
                st_nxt.dat = {26'h0, st_r.evolve_run, st_r.all_trip, st_r.gen_trip, st_r.ph_trip};
            end else if (adr_i == pst_pkg::ADDR_EVENT) begin
                st_nxt.dat = {24'h0, st_r.ev};
            end else if (adr_i == pst_pkg::ADDR_MASK) begin
                st_nxt.dat = {24'h0, st_r.mask};
            end else begin
                st_nxt.dat = 32'h0000_0000;
            end
        end

        // set wins over a same-cycle clear
        st_nxt.ev = (st_r.ev & ~ev_clr) | ev_set;
        st_nxt.irq = |(st_nxt.ev & st_nxt.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.mode <= pst_pkg::PST_MODE_OFF;
            st_r.min_pulse <= pst_pkg::MIN_PULSE_MS_RST;
            st_r.evolve <= pst_pkg::EVOLVE_MS_RST;
            st_r.ev <= pst_pkg::EV_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dat_o = st_r.dat;
    assign ack_o = st_r.ack;
    assign phase1_trip_out_o = st_r.ph_trip[0];
    assign phase2_trip_out_o = st_r.ph_trip[1];
    assign phase3_trip_out_o = st_r.ph_trip[2];
    assign general_trip_out_o = st_r.gen_trip;
    assign all_phase_trip_out_o = st_r.all_trip;
    assign irq_o = st_r.irq;

endmodule // pst_trip_logic

// ===== bench/pst_trip_logic_sva.sv
// checker: trip output and bus timing properties
module pst_trip_logic_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic output_block_in_i,
    input wire logic three_phase_request_in_i,
    input wire logic phase1_request_in_i,
    input wire logic phase2_request_in_i,
    input wire logic force_all_phases_in_i,
    input wire logic phase1_trip_out_o,
    input wire logic phase2_trip_out_o,
    input wire logic phase3_trip_out_o,
    input wire logic general_trip_out_o,
    input wire logic all_phase_trip_out_o
);
    logic any_w;
    assign any_w = phase1_trip_out_o || phase2_trip_out_o || phase3_trip_out_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // properties
    a_block_clears: assert property (output_block_in_i |=> !general_trip_out_o && !any_w)
        else $error("trip while blocked");
    a_general_any: assert property (general_trip_out_o == any_w)
        else $error("general trip disagrees");
    a_all_three: assert property (all_phase_trip_out_o == (phase1_trip_out_o && phase2_trip_out_o && phase3_trip_out_o))
        else $error("three-phase output disagrees");
    a_pair_widens: assert property (phase1_request_in_i && phase2_request_in_i && !output_block_in_i |=>
        all_phase_trip_out_o || !general_trip_out_o) else $error("pair not widened");
    a_three_widens: assert property (three_phase_request_in_i && !output_block_in_i |=>
        all_phase_trip_out_o || !general_trip_out_o) else $error("3ph request not widened");
    a_force_widens: assert property (force_all_phases_in_i && phase1_request_in_i && !output_block_in_i |=>
        all_phase_trip_out_o || !general_trip_out_o) else $error("force not widened");
    a_trip_follows: assert property (phase1_request_in_i && !output_block_in_i && general_trip_out_o
        && !(cyc_i && stb_i) |=> phase1_trip_out_o) else $error("phase trip dropped");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    c_all: cover property (all_phase_trip_out_o);
    c_end: cover property ($fell(general_trip_out_o));
    c_blk: cover property (output_block_in_i && phase1_request_in_i);
endmodule // pst_trip_logic_chk

bind pst_trip_logic pst_trip_logic_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .output_block_in_i(output_block_in_i), .three_phase_request_in_i(three_phase_request_in_i),
    .phase1_request_in_i(phase1_request_in_i), .phase2_request_in_i(phase2_request_in_i),
    .force_all_phases_in_i(force_all_phases_in_i), .phase1_trip_out_o(phase1_trip_out_o),
    .phase2_trip_out_o(phase2_trip_out_o), .phase3_trip_out_o(phase3_trip_out_o),
    .general_trip_out_o(general_trip_out_o), .all_phase_trip_out_o(all_phase_trip_out_o));

// ===== bench/pst_prot_model.sv
// partner: protection functions raising trip requests
module pst_prot_model (
    input wire logic clk_i,
    input wire logic [5:0] cmd_i,
    output logic blk_o,
    output logic single_o,
    output logic three_o,
    output logic [2:0] ph_o,
    output logic force_o
);
    // ==========================================
    // registered like real function outputs
    always_ff @(posedge clk_i) begin
        {blk_o, force_o, three_o, ph_o} <= cmd_i;
        single_o <= (|cmd_i[2:0]) && !cmd_i[3];
    end
endmodule // pst_prot_model

// ===== bench/pst_trip_logic_bench.sv
// testbench: trip logic against a behavioural model
module pst_trip_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i;
    logic rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, irq_o;
    logic blk, sgl, thr, frc;
    logic [2:0] ph;
    logic [4:0] tr;
    logic [5:0] cmd = 6'h00;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv[6] = '{32'h0, 32'h96, 32'h3e8, 32'h0, 32'h0, 32'h0};
    int cs[$] = '{3, 8, 17, 33};
    int err_count = 0, num_checks = 0, n, p;
    // ==========================================
    // clock, partner and design
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    pst_prot_model u_pst_prot_model (.clk_i(clk_i), .cmd_i(cmd), .blk_o(blk), .single_o(sgl), .three_o(thr),
        .ph_o(ph), .force_o(frc));
    pst_trip_logic #(.TICK_CYCLES(4)) u_pst_trip_logic (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .output_block_in_i(blk), .single_phase_request_in_i(sgl), .three_phase_request_in_i(thr),
        .phase1_request_in_i(ph[0]), .phase2_request_in_i(ph[1]), .phase3_request_in_i(ph[2]),
        .force_all_phases_in_i(frc), .phase1_trip_out_o(tr[0]), .phase2_trip_out_o(tr[1]),
        .phase3_trip_out_o(tr[2]), .general_trip_out_o(tr[3]), .all_phase_trip_out_o(tr[4]), .irq_o(irq_o));
    task results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            k++;
            if (k > 20) begin err_count++; results(); end
            @(posedge clk_i);
        end
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // expected trip vector {all, gen, ph3, ph2, ph1}; cmd bits: 32 block, 16 force, 8 three-phase
    function automatic logic [4:0] mdl(input int mode, input int c, input int evo);
        int p3, w;
        p3 = c & 7;
        if (mode == 0 || (c & 32) != 0 || (p3 == 0 && (c & 8) == 0)) return 5'h00;
        w = (mode == 1 || evo != 0 || (c & 24) != 0 || p3 == 3 || p3 >= 5);
        return (w != 0) ? 5'h1f : {2'b01, p3[2:0]};
    endfunction
    task pulse(input logic [5:0] c, input logic [4:0] e);
        @(posedge clk_i); cmd <= c;
        repeat (2) @(posedge clk_i);
        cmd <= 6'h00;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i); chk(tr, e);
        n = 0;
        while (tr[3] === 1'b1 && n < 300) begin @(negedge clk_i); n++; end
        if (n >= 300) begin err_count++; results(); end
    endtask
    initial begin
        p = $urandom(32'h134f7fde);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ra[i]) rchk(ra[i], rv[i]);
        wb(1'b1, 8'h04, 32'hea61); wb(1'b1, 8'h04, 32'h32); wb(1'b1, 8'h04, 32'h31);
        rchk(8'h04, 32'h32);
        wb(1'b1, 8'h08, 32'h64);
        rchk(8'h08, 32'h64);
        pulse(6'h01, mdl(0, 1, 0));
        $display("done registers and off mode");
        wb(1'b1, 8'h00, 32'h2); wb(1'b1, 8'h10, 32'hff); wb(1'b1, 8'h14, 32'hff);
        p = 1 << ($urandom % 3);
        pulse(p[5:0], mdl(2, p, 0));
        chk(n >= 190 && n <= 206, 1);
        chk(irq_o, 1'b1);
        rchk(8'h10, p | 8 | (p << 4) | 128);
        wb(1'b1, 8'h14, 32'h0); @(negedge clk_i); chk(irq_o, 1'b0);
        wb(1'b1, 8'h10, 32'hff); wb(1'b1, 8'h14, 32'hff); @(negedge clk_i); chk(irq_o, 1'b0);
        pulse(p[5:0], mdl(2, p, 1));
        n = 0;
        do begin wb(1'b0, 8'h0c, 32'h0); n++; end while (rd[5] !== 1'b0 && n < 300);
        if (rd[5] !== 1'b0) begin err_count++; results(); end
        pulse(6'h02, mdl(2, 2, 0));
        $display("done single phase and evolving window");
        foreach (cs[i]) pulse(cs[i][5:0], mdl(2, cs[i], 1));
        wb(1'b1, 8'h00, 32'h3);
        rchk(8'h00, 32'h2);
        wb(1'b1, 8'h00, 32'h1);
        pulse(6'h04, mdl(1, 4, 1));
        $display("done widening and modes");
        results();
    end
endmodule // pst_trip_logic_bench
